// *** tb/nbu_node.sv ***
// Behavioural far-end serial node that sends and collects eleven-bit frames.
`timescale 1ns/1ps
`default_nettype none
module nbu_node (
    // Clock
    input  wire logic clk_in,
    // Serial line
    input  wire logic line_in,
    output logic      line_out
);
    int         bit_clks = 16;
    logic [9:0] got_q [$];

    initial line_out = 1'b1;

    // Start zero, eight data bits LSB first, ninth bit, then the stop level.
    task automatic send(input logic [8:0] w, input logic stop, input int glitch);
        logic [10:0] fr;
        fr = {stop, w, 1'b0};
        @(posedge clk_in);
        if (glitch > 0) begin
            line_out <= 1'b0;
            repeat (glitch) @(posedge clk_in);
            line_out <= 1'b1;
            repeat (bit_clks * 2) @(posedge clk_in);
        end
        for (int i = 0; i < 11; i++) begin
            line_out <= fr[i];
            repeat (bit_clks) @(posedge clk_in);
        end
        line_out <= 1'b1;
        repeat (bit_clks) @(posedge clk_in);
    endtask : send

    // Sampling mid-bit keeps the collector tolerant of the grid alignment delay.
    always begin : collect
        logic [9:0] w;
        @(negedge line_in);
        repeat (bit_clks / 2) @(posedge clk_in);
        for (int i = 0; i < 10; i++) begin
            repeat (bit_clks) @(posedge clk_in);
            w[i] = line_in;
        end
        got_q.push_back(w);
    end
endmodule : nbu_node
`default_nettype wire

// *** tb/tb_nbu_uart.sv ***
// Self-checking bench for the nine-bit serial port with address recognition.
`timescale 1ns/1ps
`default_nettype none
module tb_nbu_uart;
    typedef struct packed {
        logic       mp;
        logic       clr;
        logic [7:0] own;
        logic [7:0] mask;
        logic [8:0] word;
        logic       load;
    } nbu_row_s;

    logic       clk_in = 1'b0;
    logic       reset_n_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic       sfr_wr_in = 1'b0;
    logic [7:0] sfr_rdata_out;
    logic       t1_ovf_in = 1'b0;
    logic       t1_run = 1'b0;
    logic       tx_fifo_ready_out;
    logic       rxd_in;
    logic       txd_out;
    logic [7:0] scb = 8'h90;
    int         bad_count = 0;
    int         check_count = 0;
    nbu_row_s   rows [8] = '{
        '{1'b0, 1'b1, 8'h00, 8'h00, 9'h05a, 1'b1},
        '{1'b1, 1'b1, 8'h00, 8'h00, 9'h0a5, 1'b0},
        '{1'b1, 1'b1, 8'h00, 8'h00, 9'h137, 1'b1},
        '{1'b1, 1'b1, 8'hc0, 8'hfd, 9'h1c2, 1'b1},
        '{1'b1, 1'b1, 8'hc0, 8'hfd, 9'h1c1, 1'b0},
        '{1'b1, 1'b1, 8'hc0, 8'hfd, 9'h1fd, 1'b1},
        '{1'b0, 1'b0, 8'hc0, 8'hfd, 9'h0aa, 1'b0},
        '{1'b1, 1'b1, 8'he0, 8'hfa, 9'h1e5, 1'b1}};

    nbu_uart #(.FIFO_DEPTH(16)) nbu_uart_i (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .sfr_addr_in(sfr_addr_in),
        .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in), .sfr_rdata_out(sfr_rdata_out),
        .t1_ovf_in(t1_ovf_in), .tx_fifo_ready_out(tx_fifo_ready_out),
        .rxd_in(rxd_in), .txd_out(txd_out));
    nbu_node nbu_node_i (.clk_in(clk_in), .line_in(txd_out), .line_out(rxd_in));

    always #5 clk_in = ~clk_in;
    // Overflow every second clock makes mode 3 run at the same rate as mode 2 at osc/32.
    always @(posedge clk_in) t1_ovf_in <= t1_run & ~t1_ovf_in;

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        sfr_wr_in <= 1'b1;
        @(posedge clk_in);
        sfr_wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                      input string nm);
        @(posedge clk_in);
        sfr_addr_in <= a;
        @(posedge clk_in);
        #1;
        chk(nm, e, sfr_rdata_out & m);
    endtask : rd

    task automatic waitf(input int n);
        for (int t = 0; t < 20000 && nbu_node_i.got_q.size() < n; t++) begin
            @(posedge clk_in);
        end
    endtask : waitf

    task automatic txchk(input logic [8:0] w);
        wr(8'h98, scb | {4'h0, w[8], 3'h0});
        wr(8'h99, w[7:0]);
        waitf(1);
        chk("tx_frame", {1'b1, w}, nbu_node_i.got_q.pop_front());
        rd(8'h98, 8'h02, 8'h02, "tx_done_flag");
    endtask : txchk

    task automatic rxchk(input logic [8:0] w, input int g);
        wr(8'h98, scb);
        nbu_node_i.send(w, 1'b1, g);
        rd(8'h99, 8'hff, w[7:0], "serial_buffer");
    endtask : rxchk

    task automatic conclude();
        if (bad_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    initial begin : watchdog
        repeat (60000) @(posedge clk_in);
        bad_count++;
        conclude();
    end

    initial begin : main
        int         n;
        logic [7:0] rb_v;
        logic       rb8_v;
        logic       mp_v;
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1;
        chk("txd_out", 16'h1, txd_out);
        chk("tx_fifo_ready", 16'h1, tx_fifo_ready_out);
        rd(8'ha9, 8'hff, 8'h00, "own_slave_address");
        rd(8'hb9, 8'hff, 8'h00, "slave_address_mask");
        wr(8'h10, 8'h55);
        rd(8'h10, 8'hff, 8'h00, "unmapped");
        wr(8'h87, 8'h80);
        mp_v = 1'b0;
        rb_v = 8'h00;
        rb8_v = 1'b0;
        foreach (rows[k]) begin
            wr(8'ha9, rows[k].own);
            wr(8'hb9, rows[k].mask);
            if (rows[k].clr) begin
                mp_v = rows[k].mp;
                rb8_v = 1'b0;
                wr(8'h98, {2'b10, mp_v, 5'h10});
            end
            nbu_node_i.send(rows[k].word, 1'b1, 0);
            if (rows[k].load) begin
                rb_v = rows[k].word[7:0];
                rb8_v = rows[k].word[8];
            end
            rd(8'h99, 8'hff, rb_v, "serial_buffer");
            rd(8'h98, 8'hff, {2'b10, mp_v, 2'b10, rb8_v, 1'b0, rows[k].load | ~rows[k].clr},
               "serial_control");
        end
        wr(8'h98, scb);
        n = 0;
        while (n < 40) begin
            @(negedge clk_in);
            if (tx_fifo_ready_out !== 1'b1) break;
            wr(8'h99, n[7:0]);
            n++;
        end
        chk("fifo_fill", 16'h1, n >= 16);
        waitf(n);
        chk("burst_count", n[15:0], nbu_node_i.got_q.size());
        for (int i = 0; i < n; i++) begin
            chk("burst_frame", {8'h02, i[7:0]}, nbu_node_i.got_q.pop_front());
        end
        txchk(9'h1a5);
        wr(8'h98, 8'h90);
        wr(8'h87, 8'hc0);
        nbu_node_i.send(9'h033, 1'b0, 0);
        rd(8'h98, 8'h81, 8'h81, "frame_error_flag");
        rd(8'h99, 8'hff, 8'h33, "serial_buffer");
        nbu_node_i.send(9'h044, 1'b1, 0);
        rd(8'h98, 8'h80, 8'h80, "frame_error_flag");
        wr(8'h98, 8'h10);
        rd(8'h98, 8'h81, 8'h00, "frame_error_flag");
        wr(8'h87, 8'h80);
        rd(8'h98, 8'h80, 8'h80, "serial_mode_bit0");
        rxchk(9'h066, 3);
        wr(8'h87, 8'h00);
        nbu_node_i.bit_clks = 32;
        txchk(9'h13c);
        rxchk(9'h0c3, 0);
        scb = 8'hd0;
        t1_run = 1'b1;
        wr(8'h87, 8'h80);
        txchk(9'h05a);
        rxchk(9'h1a5, 0);
        wr(8'h98, 8'h70);
        nbu_node_i.send(9'h1e5, 1'b1, 0);
        rd(8'h98, 8'h05, 8'h05, "mode1_control");
        rd(8'h99, 8'hff, 8'he5, "serial_buffer");
        wr(8'h98, 8'h70);
        nbu_node_i.send(9'h0e1, 1'b1, 0);
        rd(8'h98, 8'h01, 8'h00, "rx_done_flag");
        rd(8'h99, 8'hff, 8'he5, "serial_buffer");
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rd(8'ha9, 8'hff, 8'h00, "own_slave_address");
        rd(8'hb9, 8'hff, 8'h00, "slave_address_mask");
        conclude();
    end
endmodule : tb_nbu_uart
`default_nettype wire

// *** verilog/nbu_pkg.sv ***
// Types shared by the nine-bit serial port design.
`default_nettype none
package nbu_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA} nbu_tx_e;
    typedef enum logic [1:0] {RX_HUNT, RX_BITS, RX_STOP} nbu_rx_e;
    typedef struct packed {
        nbu_tx_e     tx_st;
        logic [8:0]  tx_sr;
        logic        tx_first;
        logic [3:0]  tx_cnt;
        logic        txd;
        nbu_rx_e     rx_st;
        logic [8:0]  rx_sr;
        logic [3:0]  rx_cnt;
        logic [1:0]  smp;
        logic        rxd_prev;
        logic        half;
        logic [7:0]  rx_buf;
        logic        sm0;
        logic        sm1;
        logic        sm2;
        logic        ren;
        logic        tb8;
        logic        rb8;
        logic        ti;
        logic        ri;
        logic        fe;
        logic        smod1;
        logic        fe_sel;
        logic [7:0]  own_slave_address;
        logic [7:0]  slave_address_mask;
        logic [7:0]  rdata;
    } nbu_state_s;
endpackage : nbu_pkg
`default_nettype wire

// *** verilog/nbu_regs.svh ***
// Register addresses, field positions, reset values and timing counts of the nine-bit serial port.
`ifndef NBU_REGS_SVH
`define NBU_REGS_SVH

`define NBU_ADDR_PWR_CTRL   8'h87
`define NBU_ADDR_SER_CTRL   8'h98
`define NBU_ADDR_SER_BUF    8'h99
`define NBU_ADDR_OWN_ADDR   8'ha9
`define NBU_ADDR_ADDR_MASK  8'hb9

`define NBU_SC_MODE0_FE     7
`define NBU_SC_MODE1        6
`define NBU_SC_MP_EN        5
`define NBU_SC_RX_EN        4
`define NBU_SC_TX_NINTH     3
`define NBU_SC_RX_NINTH     2
`define NBU_SC_TX_DONE      1
`define NBU_SC_RX_DONE      0

`define NBU_PC_RATE_DOUBLE  7
`define NBU_PC_FE_SELECT    6

`define NBU_RESET_BYTE      8'h00
`define NBU_RX_PRESET       9'h1ff
`define NBU_CNT_LAST        4'hf
`define NBU_SAMPLE_A        4'h7
`define NBU_SAMPLE_B        4'h8
`define NBU_SAMPLE_C        4'h9

`endif

// *** verilog/nbu_uart.sv ***
// Nine-bit serial port with address recognition, framing error flag and transmit FIFO.
//
// Overview of operation
// - Frame is start zero, eight data bits LSB first, ninth bit, stop one.
// - Transmit tx_ninth_bit as ninth bit; received ninth bit goes to rx_ninth_bit.
// - Mode 2 rate is osc/16 or osc/32; mode 3 uses Timer 1 overflows.
// - Writing serial_buffer requests a transmission carrying tx_ninth_bit as ninth bit.
// - Transmission starts at the next divide-by-16 rollover, not at the write.
// - Start bit first, data output one bit later, first shift one more later.
// - First shift inserts the stop one at top, later shifts insert zeros.
// - When ninth bit reaches output, final shift, stop sending, set tx_done_flag.
// - Sample line at sixteen times bit rate; falling edge resets counter, presets 1FFH.
// - Majority of samples at states 7, 8, 9; bad start bit returns to hunting.
// - Load buffer and flag only if flag clear and compare disabled or ninth set.
// - Failed load discards frame; hunting resumes one bit time after final shift in modes 2/3, at the final shift in mode 1.
// - Received stop bit never affects buffer, rx_ninth_bit or rx_done_flag in modes 2/3.
// - A received frame without valid stop bit sets frame_error_flag.
// - Control bit 7 is frame_error_flag when fe_select set, else serial_mode_bit0.
// - Only a software write clears frame_error_flag.
// - With compare enabled, ninth-bit-one frames load only on given or broadcast match.
// - Mode 1 compare needs valid stop and address match; mode 0 never arms the receiver.
// - Given address is own address ANDed with mask; mask zeros are don't-care.
// - Broadcast address is own address ORed with mask; its zeros are don't-care.
// - Reset clears own address and mask, so every address matches.
`timescale 1ns/1ps
`default_nettype none
`include "nbu_regs.svh"

module nbu_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [CW-1:0]               cnt;
    } nbu_fifo_s;
    nbu_fifo_s q;
    nbu_fifo_s d;
    logic push;
    logic pop;

    assign in_ready_out  = (q.cnt != CW'(DEPTH));
    assign out_valid_out = (q.cnt != '0);
    assign out_data_out  = q.mem[q.rd];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr] = in_data_in;
            d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + AW'(1);
        end
        if (pop) begin
            d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + AW'(1);
        end
        d.cnt = q.cnt + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : nbu_fifo

module nbu_uart #(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    // Special function register port
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic [7:0] sfr_wdata_in,
    input  wire logic       sfr_wr_in,
    output logic [7:0]      sfr_rdata_out,
    // Baud source and transmit back-pressure
    input  wire logic       t1_ovf_in,
    output logic            tx_fifo_ready_out,
    // Serial line
    input  wire logic       rxd_in,
    output logic            txd_out
);
    nbu_pkg::nbu_state_s q;
    nbu_pkg::nbu_state_s d;
    logic       tick;
    logic       tx_roll;
    logic       fifo_valid;
    logic       fifo_pop;
    logic [8:0] fifo_data;
    logic       buf_wr;
    logic       ctrl_wr;
    logic [1:0] mode;
    logic       vote;
    logic       sample_now;
    logic       final_shift;
    logic       load_ok;
    logic       addr_ok;
    logic [7:0] given;
    logic [7:0] bcast;
    logic [7:0] rx_data;

    assign mode    = {q.sm0, q.sm1};
    assign buf_wr  = sfr_wr_in && (sfr_addr_in == `NBU_ADDR_SER_BUF);
    assign ctrl_wr = sfr_wr_in && (sfr_addr_in == `NBU_ADDR_SER_CTRL);
    // Mode 2 ticks on the clock, mode 1/3 on overflows; halved unless doubled.
    assign tick    = ((mode == 2'b10) ? 1'b1 : t1_ovf_in) && (q.smod1 || q.half);
    assign tx_roll = tick && (q.tx_cnt == `NBU_CNT_LAST);
    // The FIFO drains only on a rollover, so bit times stay on the counter grid.
    assign fifo_pop = (q.tx_st == nbu_pkg::TX_IDLE) && tx_roll && (mode != 2'b00);
    assign sample_now = tick && (q.rx_cnt == `NBU_SAMPLE_C);
    assign vote = (q.smp[1] & q.smp[0]) | (q.smp[1] & rxd_in) | (q.smp[0] & rxd_in);
    assign final_shift = sample_now && (q.rx_st == nbu_pkg::RX_BITS) && !q.rx_sr[0];
    assign rx_data = q.rx_sr[8:1];
    assign given = q.own_slave_address & q.slave_address_mask;
    assign bcast = q.own_slave_address | q.slave_address_mask;
    assign addr_ok = (((rx_data ^ given) & q.slave_address_mask) == 8'h00) ||
                     (((rx_data ^ bcast) & bcast) == 8'h00);
    // In mode 1 the vote at the final shift is the stop bit itself.
    assign load_ok = !q.ri && (!q.sm2 || (vote && addr_ok));
    assign txd_out = q.txd;
    assign sfr_rdata_out = q.rdata;

    // The ninth bit rides with each byte so a later tx_ninth_bit change cannot alter it.
    nbu_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_in        (clk_in),
        .reset_n_in    (reset_n_in),
        .in_valid_in   (buf_wr),
        .in_ready_out  (tx_fifo_ready_out),
        .in_data_in    ({q.tb8, sfr_wdata_in}),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_data)
    );

    always_comb begin
        d = q;
        d.half = q.half ^ ((mode == 2'b10) ? 1'b1 : t1_ovf_in);
        // Software writes first; hardware sets below win in the same cycle.
        if (ctrl_wr) begin
            if (q.fe_sel) begin
                d.fe = sfr_wdata_in[`NBU_SC_MODE0_FE];
            end else begin
                d.sm0 = sfr_wdata_in[`NBU_SC_MODE0_FE];
            end
            d.sm1 = sfr_wdata_in[`NBU_SC_MODE1];
            d.sm2 = sfr_wdata_in[`NBU_SC_MP_EN];
            d.ren = sfr_wdata_in[`NBU_SC_RX_EN];
            d.tb8 = sfr_wdata_in[`NBU_SC_TX_NINTH];
            d.rb8 = sfr_wdata_in[`NBU_SC_RX_NINTH];
            d.ti  = sfr_wdata_in[`NBU_SC_TX_DONE];
            d.ri  = sfr_wdata_in[`NBU_SC_RX_DONE];
        end
        if (sfr_wr_in && (sfr_addr_in == `NBU_ADDR_PWR_CTRL)) begin
            d.smod1  = sfr_wdata_in[`NBU_PC_RATE_DOUBLE];
            d.fe_sel = sfr_wdata_in[`NBU_PC_FE_SELECT];
        end
        if (sfr_wr_in && (sfr_addr_in == `NBU_ADDR_OWN_ADDR)) begin
            d.own_slave_address = sfr_wdata_in;
        end
        if (sfr_wr_in && (sfr_addr_in == `NBU_ADDR_ADDR_MASK)) begin
            d.slave_address_mask = sfr_wdata_in;
        end
        // Transmitter.
        if (tick) begin
            d.tx_cnt = q.tx_cnt + 4'h1;
        end
        case (q.tx_st)
            nbu_pkg::TX_IDLE: begin
                d.txd = 1'b1;
                if (fifo_pop && fifo_valid) begin
                    d.tx_sr    = fifo_data;
                    d.tx_first = 1'b1;
                    d.tx_st    = nbu_pkg::TX_START;
                    d.txd      = 1'b0;
                end
            end
            nbu_pkg::TX_START: begin
                if (tx_roll) begin
                    d.tx_st = nbu_pkg::TX_DATA;
                    d.txd   = q.tx_sr[0];
                end
            end
            nbu_pkg::TX_DATA: begin
                if (tx_roll) begin
                    if (!q.tx_first && (q.tx_sr[8:1] == 8'h01)) begin
                        d.tx_sr = {1'b0, q.tx_sr[8:1]};
                        d.tx_st = nbu_pkg::TX_IDLE;
                        d.ti    = 1'b1;
                        d.txd   = 1'b1;
                    end else begin
                        d.tx_sr    = {q.tx_first, q.tx_sr[8:1]};
                        d.tx_first = 1'b0;
                        d.txd      = q.tx_sr[1];
                    end
                end
            end
            default: begin
                d.tx_st = nbu_pkg::TX_IDLE;
            end
        endcase
        // Receiver.
        if (tick) begin
            d.rxd_prev = rxd_in;
            d.rx_cnt   = q.rx_cnt + 4'h1;
            if ((q.rx_cnt == `NBU_SAMPLE_A) || (q.rx_cnt == `NBU_SAMPLE_B)) begin
                d.smp = {q.smp[0], rxd_in};
            end
        end
        case (q.rx_st)
            nbu_pkg::RX_HUNT: begin
                if (tick && q.ren && (mode != 2'b00) && q.rxd_prev && !rxd_in) begin
                    d.rx_cnt = 4'h0;
                    d.rx_sr  = `NBU_RX_PRESET;
                    d.rx_st  = nbu_pkg::RX_BITS;
                end
            end
            nbu_pkg::RX_BITS: begin
                if (sample_now) begin
                    if ((q.rx_sr == `NBU_RX_PRESET) && vote) begin
                        d.rx_st = nbu_pkg::RX_HUNT;
                    end else if (!q.rx_sr[0]) begin
                        d.rx_sr = {vote, q.rx_sr[8:1]};
                        if (load_ok) begin
                            d.rx_buf = rx_data;
                            d.rb8    = vote;
                            d.ri     = 1'b1;
                        end
                        if (mode == 2'b01) begin
                            d.rx_st = nbu_pkg::RX_HUNT;
                            if (!vote) begin
                                d.fe = 1'b1;
                            end
                        end else begin
                            d.rx_st = nbu_pkg::RX_STOP;
                        end
                    end else begin
                        d.rx_sr = {vote, q.rx_sr[8:1]};
                    end
                end
            end
            nbu_pkg::RX_STOP: begin
                // The stop value reaches only the error flag, never the data path.
                if (sample_now) begin
                    d.rx_st = nbu_pkg::RX_HUNT;
                    if (!vote) begin
                        d.fe = 1'b1;
                    end
                end
            end
            default: begin
                d.rx_st = nbu_pkg::RX_HUNT;
            end
        endcase
        // Registered read data, valid one cycle after the address.
        case (sfr_addr_in)
            `NBU_ADDR_SER_CTRL: begin
                d.rdata = {q.fe_sel ? q.fe : q.sm0, q.sm1, q.sm2, q.ren,
                           q.tb8, q.rb8, q.ti, q.ri};
            end
            `NBU_ADDR_SER_BUF:   d.rdata = q.rx_buf;
            `NBU_ADDR_PWR_CTRL:  d.rdata = {q.smod1, q.fe_sel, 6'h00};
            `NBU_ADDR_OWN_ADDR:  d.rdata = q.own_slave_address;
            `NBU_ADDR_ADDR_MASK: d.rdata = q.slave_address_mask;
            default:             d.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            q       <= '0;
            q.txd   <= 1'b1;
            q.rx_sr <= `NBU_RX_PRESET;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_idle_high;
        (q.tx_st == nbu_pkg::TX_IDLE) |-> txd_out;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("line not high while idle");

    property p_start_low;
        (q.tx_st == nbu_pkg::TX_START) |-> !txd_out;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit not low");

    property p_done_from_data;
        $rose(q.ti) && !$past(ctrl_wr) |-> $past(q.tx_st) == nbu_pkg::TX_DATA && $past(tx_roll);
    endproperty
    a_done_from_data: assert property (p_done_from_data) else $error("tx done set out of step");

    property p_write_queued;
        buf_wr && tx_fifo_ready_out |=> fifo_valid;
    endproperty
    a_write_queued: assert property (p_write_queued) else $error("write did not queue a frame");

    property p_start_aligned;
        $rose(q.tx_st == nbu_pkg::TX_START) |-> $past(tx_roll) && (q.tx_cnt == 4'h0);
    endproperty
    a_start_aligned: assert property (p_start_aligned) else $error("start off counter grid");

    property p_edge_arms;
        (q.rx_st == nbu_pkg::RX_HUNT) && tick && q.ren && (mode != 2'b00) && q.rxd_prev && !rxd_in
        |=> (q.rx_st == nbu_pkg::RX_BITS) && (q.rx_cnt == 4'h0) && (q.rx_sr == 9'h1ff);
    endproperty
    a_edge_arms: assert property (p_edge_arms) else $error("falling edge did not arm receiver");

    property p_false_start;
        sample_now && (q.rx_st == nbu_pkg::RX_BITS) && (q.rx_sr == 9'h1ff) && vote
        |=> q.rx_st == nbu_pkg::RX_HUNT;
    endproperty
    a_false_start: assert property (p_false_start) else $error("false start not rejected");

    property p_ri_cause;
        $rose(q.ri) && !$past(ctrl_wr) |-> $past(final_shift) && $past(load_ok);
    endproperty
    a_ri_cause: assert property (p_ri_cause) else $error("rx done set without load");

    // A software write in the same cycle may legally change rx_ninth_bit on its own.
    property p_lost_frame;
        final_shift && q.ri && !ctrl_wr |=> $stable(q.rx_buf) && $stable(q.rb8);
    endproperty
    a_lost_frame: assert property (p_lost_frame) else $error("blocked frame changed buffer");

    property p_fe_sticky;
        q.fe && !(ctrl_wr && q.fe_sel) |=> q.fe;
    endproperty
    a_fe_sticky: assert property (p_fe_sticky) else $error("error flag cleared by hardware");

    property p_fast_rate;
        (mode == 2'b10) && q.smod1 |-> tick;
    endproperty
    a_fast_rate: assert property (p_fast_rate) else $error("mode 2 fast rate missed a tick");

    property p_load_ninth;
        final_shift && load_ok |=> (q.rb8 == $past(vote)) && (q.rx_buf == $past(rx_data));
    endproperty
    a_load_ninth: assert property (p_load_ninth) else $error("accepted frame not loaded");

    property p_stop_ignored;
        sample_now && (q.rx_st == nbu_pkg::RX_STOP) && !ctrl_wr
        |=> $stable(q.rx_buf) && $stable(q.rb8) && $stable(q.ri);
    endproperty
    a_stop_ignored: assert property (p_stop_ignored) else $error("stop bit reached data path");

    c_tx_done: cover property ($rose(q.ti));
    c_rx_load: cover property (final_shift && load_ok);
    c_fe_set: cover property ($rose(q.fe));
    c_false_start: cover property (sample_now && (q.rx_sr == 9'h1ff) && vote);
endmodule : nbu_uart
`default_nettype wire
